// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    logic        mclk;
    logic        reset;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        ext_in;
    logic        tout;
    logic        tout_sel;
    logic        irq0;
    logic        irq1;
    int          errors;
    int          n_compared;
    int          cyc;
    integer      seed;
    logic [7:0]  exp_rd[$];
    int          exp_gap0[$];
    int          exp_gap1[$];
    int          last0;
    int          last1;
    int          hits0;
    int          hits1;
    logic [1:0]  outsel;
    logic        rd_q;
    logic        out_prev;
    logic        ext_run;

    dpt_timers uut (
        .MCLK                  (mclk),
        .RESET                 (reset),
        .REG_ADDR              (reg_addr),
        .REG_WR                (reg_wr),
        .REG_RD                (reg_rd),
        .REG_WDATA             (reg_wdata),
        .REG_RDATA             (reg_rdata),
        .TIMER_EXT_CLOCK_INPUT (ext_in),
        .PORT3_LINE_SIX_OUT    (tout),
        .PORT3_LINE_SIX_SEL    (tout_sel),
        .TIMER_ZERO_INTERRUPT  (irq0),
        .TIMER_ONE_INTERRUPT   (irq1)
    );

    // Clock, 10 ns period
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Compare one value and count it
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
        n_compared++;
        if (seen !== expv) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, expv, seen);
        end
    endtask

    // Print counts and verdict, then stop
    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Register write, one strobe cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask

    // Register read; expected answer noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        exp_rd.push_back(e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
    endtask

    // Interrupt seen: check output toggle and spacing against the oldest note
    task automatic on_irq(input string what, input logic mine, ref int last, ref int q[$],
                          ref int hits);
        int gap;
        hits++;
        if (mine) check("toggle", {15'h0, tout}, {15'h0, ~out_prev});
        if (last >= 0) begin
            gap = (q.size() > 0) ? q.pop_front() : -1;
            if (gap != 0) check(what, 16'(cyc - last), 16'(gap));
        end
        last = cyc;
    endtask

    // Wait until all noted intervals have been seen
    task automatic drain(ref int q[$]);
        int k;
        k = 0;
        while (q.size() > 0 && k < 12000) begin
            @(negedge mclk);
            k++;
        end
        check("drain_left", 16'(q.size()), 16'h0000);
    endtask

    // Run the first timer in continuous mode with the output following it
    task automatic run_zero(input logic [7:0] cfg, input logic [7:0] init, input int gap);
        wr(dpt_pkg::ADDR_TMODE, 8'h00);
        last0 = -1;
        outsel = 2'h1;
        repeat (3) exp_gap0.push_back(gap);
        wr(dpt_pkg::ADDR_PZERO_CFG, cfg);
        wr(dpt_pkg::ADDR_TZERO_CNT, init);
        wr(dpt_pkg::ADDR_TMODE, 8'h43);
        rd(dpt_pkg::ADDR_TMODE, 8'h42);
        check("sel_on", {15'h0, tout_sel}, 16'h0001);
        drain(exp_gap0);
    endtask

    // Read strobe seen at the rising edge, cycle count, run limit
    always @(posedge mclk) begin
        rd_q <= reg_rd;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end

    // Output monitor: read answers and interrupt spacing
    always @(negedge mclk) begin
        if (rd_q) begin
            if (exp_rd.size() == 0) check("read_extra", {8'h0, reg_rdata}, 16'hFFFF);
            else check("read_data", {8'h0, reg_rdata}, {8'h0, exp_rd.pop_front()});
        end
        if (irq0) on_irq("gap_zero", outsel == 2'h1, last0, exp_gap0, hits0);
        if (irq1) on_irq("gap_one", outsel == 2'h2, last1, exp_gap1, hits1);
        out_prev = tout;
    end

    // External count input: rising edge every 6 cycles while enabled
    initial begin
        ext_in = 1'b0;
        forever begin
            repeat (3) @(negedge mclk);
            if (ext_run) ext_in = ~ext_in;
        end
    end

    // Main sequence
    initial begin
        logic [5:0] m;
        logic [7:0] v;
        int         h;
        logic       p;
        seed = 32'he5c3fec8;
        reset = 1'b1;
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        errors = 0;
        n_compared = 0;
        cyc = 0;
        last0 = -1;
        last1 = -1;
        hits0 = 0;
        hits1 = 0;
        outsel = 2'h0;
        rd_q = 1'b0;
        out_prev = 1'b0;
        ext_run = 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        reset = 1'b0;
        // Write-only prescalers and an unmapped location
        wr(dpt_pkg::ADDR_PZERO_CFG, 8'h05);
        wr(8'h10, 8'hA5);
        rd(dpt_pkg::ADDR_PZERO_CFG, dpt_pkg::PRESCALE_READ);
        rd(dpt_pkg::ADDR_PONE_CFG, dpt_pkg::PRESCALE_READ);
        rd(8'h10, dpt_pkg::UNMAPPED_READ);
        // Boundary moduli and counts, then random ones
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 6'h00 : (i == 1) ? 6'h01 : 6'(1 + $unsigned($random(seed)) % 3);
            v = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'(1 + $unsigned($random(seed)) % 5);
            run_zero({m, 2'b01}, v, 4 * ((m == 0) ? 64 : m) * ((v == 0) ? 256 : v));
        end
        // New initial value written while running takes effect at reload
        run_zero(8'h05, 8'h02, 8);
        exp_gap0.push_back(0);
        exp_gap0.push_back(12);
        exp_gap0.push_back(12);
        wr(dpt_pkg::ADDR_TZERO_CNT, 8'h03);
        drain(exp_gap0);
        // Second timer counting the external input
        wr(dpt_pkg::ADDR_TMODE, 8'h00);
        @(negedge mclk);
        check("sel_off", {15'h0, tout_sel}, 16'h0000);
        outsel = 2'h2;
        repeat (3) exp_gap1.push_back(18);
        ext_run = 1'b1;
        wr(dpt_pkg::ADDR_PONE_CFG, 8'h05);
        wr(dpt_pkg::ADDR_TONE_CNT, 8'h03);
        wr(dpt_pkg::ADDR_TMODE, 8'h8C);
        rd(dpt_pkg::ADDR_TMODE, 8'h88);
        drain(exp_gap1);
        wr(dpt_pkg::ADDR_TMODE, 8'h00);
        ext_run = 1'b0;
        outsel = 2'h0;
        // Second timer single-pass on the internal clock: one end-of-count, then holds at 00
        last1 = -1;
        h = hits1;
        wr(dpt_pkg::ADDR_PONE_CFG, 8'h08);
        wr(dpt_pkg::ADDR_TONE_CNT, 8'h02);
        wr(dpt_pkg::ADDR_TMODE, 8'h0C);
        repeat (120) @(negedge mclk);
        check("single_hits", 16'(hits1 - h), 16'h0001);
        rd(dpt_pkg::ADDR_TONE_CNT, 8'h00);
        // Internal clock image on the output line
        wr(dpt_pkg::ADDR_TMODE, 8'hC0);
        outsel = 2'h3;
        repeat (2) @(negedge mclk);
        repeat (4) begin
            p = tout;
            @(negedge mclk);
            check("clk_out", {15'h0, tout}, {15'h0, ~p});
        end
        complete_run();
    end
endmodule

// *** src/dpt_pkg.sv ***
package dpt_pkg;
    // Register file locations
    localparam logic [7:0] ADDR_TMODE     = 8'hF1;
    localparam logic [7:0] ADDR_TONE_CNT  = 8'hF2;
    localparam logic [7:0] ADDR_PONE_CFG  = 8'hF3;
    localparam logic [7:0] ADDR_TZERO_CNT = 8'hF4;
    localparam logic [7:0] ADDR_PZERO_CFG = 8'hF5;

    // Read answers for write-only and unmapped locations
    localparam logic [7:0] PRESCALE_READ = 8'hFF;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Timer mode control field positions
    localparam int TM_LOAD0_BIT  = 0;
    localparam int TM_EN0_BIT    = 1;
    localparam int TM_LOAD1_BIT  = 2;
    localparam int TM_EN1_BIT    = 3;
    localparam int TM_OUTSEL_LSB = 6;

    // Prescaler configuration field positions
    localparam int PCFG_MODE_BIT = 0;
    localparam int PCFG_EXT_BIT  = 2;
    localparam int PCFG_MOD_LSB  = 2;
    localparam int PCFG_MOD_W    = 6;

    // Timer output source selection
    localparam logic [1:0] OUTSEL_OFF  = 2'h0;
    localparam logic [1:0] OUTSEL_ZERO = 2'h1;
    localparam logic [1:0] OUTSEL_ONE  = 2'h2;
    localparam logic [1:0] OUTSEL_CLK  = 2'h3;

    // Timer clock divider: internal clock divided by four
    localparam int         DIV_RATIO = 4;
    localparam logic [1:0] DIV_LAST  = 2'(DIV_RATIO - 1);

    // Reset values
    localparam logic [7:0] TMODE_RST = 8'h00;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [7:0] INIT_RST  = 8'h00;
    localparam logic [7:0] CNT_RST   = 8'h00;
    localparam logic [5:0] PRE_RST   = 6'h00;
    localparam logic [1:0] DIV_RST   = 2'h0;
    localparam logic       TOUT_RST  = 1'b0;
    localparam logic [7:0] RDATA_RST = 8'h00;
endpackage

// *** src/dpt_timers.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Two independent 8-bit down-counters, each fed by its own 6-bit prescaler.
// - Single-pass stops at end-of-count; continuous reloads initial value and continues.
// - Initial values transfer immediately on load, or at end-of-count when continuous.
// - Counter and prescaler registers accept writes while the timer runs.
// - Both timers count on a timer clock equal to internal clock divided by four.
// - Divide-by-four, prescaler and timer form one synchronous 16-bit divide chain.
// - Second timer may count an external input pin instead of the timer clock.
// - Output line selectable to carry first timer, second timer or internal clock.
// - Selected timer reaching end-of-count inverts the timer output level.
// - Timer, prescaler and mode registers are plain register-file locations.
// - Prescalers: 8-bit holding register and 6-bit down-counter, at F5h and F3h.
// - Prescaler registers are write-only and always read back as all ones.
// - Upper six prescaler bits hold the modulus, 1 to 64.
// - Prescaler bit 0 selects counting mode; bit 2, also the modulus low bit, selects second timer clock source.
// - Timer registers: down-counter, write-only initial, read-only count, F4h and F2h.
// - Initial value spans 1 to 256; zero counts as 256.
// - Timers count without any software involvement once started.
// - Load bit copies initial values into down-counters; next clock clears it.
// - Timer and prescaler both at end-of-count raise that timer's interrupt.
// - Prescaler bit 0 selects single-pass (0) or continuous (1) mode.
// - Second prescaler bit 2 set selects the external pin as clock source.
module dpt_timers (
    input  wire logic       MCLK,                  // Internal clock
    input  wire logic       RESET,                 // Synchronous reset, active high
    input  wire logic [7:0] REG_ADDR,              // Register file address
    input  wire logic       REG_WR,                // Write strobe
    input  wire logic       REG_RD,                // Read strobe
    input  wire logic [7:0] REG_WDATA,             // Write data
    output logic      [7:0] REG_RDATA,             // Read data, one cycle after strobe
    input  wire logic       TIMER_EXT_CLOCK_INPUT, // External count input
    output logic            PORT3_LINE_SIX_OUT,    // Timer output level
    output logic            PORT3_LINE_SIX_SEL,    // Timer output owns the line
    output logic            TIMER_ZERO_INTERRUPT,  // First timer end-of-count pulse
    output logic            TIMER_ONE_INTERRUPT    // Second timer end-of-count pulse
);

    typedef struct packed {
        logic [1:0] div;
        logic [7:0] tmode;
        logic [7:0] cfg0;
        logic [7:0] cfg1;
        logic [7:0] init0;
        logic [7:0] init1;
        logic [7:0] cnt0;
        logic [7:0] cnt1;
        logic [5:0] prescale_zero_config;
        logic [5:0] prescale_one_config;
        logic       done0;
        logic       done1;
        logic       ext_prev;
        logic       tout;
        logic       tout_on;
        logic       clk_half;
        logic       irq0;
        logic       irq1;
        logic [7:0] rdata;
    } dpt_state_t;

    localparam dpt_state_t ST_RST = '{
        div:      dpt_pkg::DIV_RST,
        tmode:    dpt_pkg::TMODE_RST,
        cfg0:     dpt_pkg::CFG_RST,
        cfg1:     dpt_pkg::CFG_RST,
        init0:    dpt_pkg::INIT_RST,
        init1:    dpt_pkg::INIT_RST,
        cnt0:     dpt_pkg::CNT_RST,
        cnt1:     dpt_pkg::CNT_RST,
        prescale_zero_config:     dpt_pkg::PRE_RST,
        prescale_one_config:     dpt_pkg::PRE_RST,
        done0:    1'b0,
        done1:    1'b0,
        ext_prev: 1'b0,
        tout:     dpt_pkg::TOUT_RST,
        tout_on:  1'b0,
        clk_half: 1'b0,
        irq0:     1'b0,
        irq1:     1'b0,
        rdata:    dpt_pkg::RDATA_RST
    };

    dpt_state_t st_ff;
    dpt_state_t nxt_st;

    logic       tick;
    logic       ext_rise;
    logic       run0;
    logic       run1;
    logic       carry0;
    logic       carry1;
    logic       eoc0;
    logic       eoc1;
    logic       load0;
    logic       load1;
    logic [1:0] outsel;

    // True when a down-counter sits at its last count
    function automatic logic at_one(input logic [7:0] v);
        return v == 8'h01;
    endfunction

    // Prescaler modulus field; zero gives 64 since the counter wraps
    function automatic logic [5:0] modulus(input logic [7:0] cfg);
        return cfg[dpt_pkg::PCFG_MOD_LSB +: dpt_pkg::PCFG_MOD_W];
    endfunction

    // Next state of the whole block
    always_comb begin
        nxt_st = st_ff;

        // Free-running divide-by-four stage
        tick       = st_ff.div == dpt_pkg::DIV_LAST;
        nxt_st.div = 2'(st_ff.div + 2'h1);

        // External input edge for the second timer
        ext_rise        = TIMER_EXT_CLOCK_INPUT & ~st_ff.ext_prev;
        nxt_st.ext_prev = TIMER_EXT_CLOCK_INPUT;

        load0  = st_ff.tmode[dpt_pkg::TM_LOAD0_BIT];
        load1  = st_ff.tmode[dpt_pkg::TM_LOAD1_BIT];
        outsel = st_ff.tmode[dpt_pkg::TM_OUTSEL_LSB +: 2];

        // Count pulses into each prescaler, gated by enable, single-pass stop and a
        // pending load, so stale counts cannot raise an end-of-count during a load
        run0 = st_ff.tmode[dpt_pkg::TM_EN0_BIT] & tick & ~st_ff.done0 & ~load0;
        run1 = st_ff.tmode[dpt_pkg::TM_EN1_BIT] & ~st_ff.done1 & ~load1 &
               (st_ff.cfg1[dpt_pkg::PCFG_EXT_BIT] ? ext_rise : tick);

        carry0 = run0 & at_one({2'h0, st_ff.prescale_zero_config});
        carry1 = run1 & at_one({2'h0, st_ff.prescale_one_config});
        eoc0   = carry0 & at_one(st_ff.cnt0);
        eoc1   = carry1 & at_one(st_ff.cnt1);

        // First prescaler: decrement, reload modulus on carry
        if (run0) begin
            nxt_st.prescale_zero_config = carry0 ? modulus(st_ff.cfg0) : 6'(st_ff.prescale_zero_config - 6'h01);
        end
        // Second prescaler
        if (run1) begin
            nxt_st.prescale_one_config = carry1 ? modulus(st_ff.cfg1) : 6'(st_ff.prescale_one_config - 6'h01);
        end

        // First timer: one decrement per carry; zero start counts as 256
        if (carry0) begin
            if (eoc0 && st_ff.cfg0[dpt_pkg::PCFG_MODE_BIT]) begin
                nxt_st.cnt0 = st_ff.init0;
            end else if (eoc0) begin
                nxt_st.cnt0  = 8'h00;
                nxt_st.done0 = 1'b1;
            end else begin
                nxt_st.cnt0 = 8'(st_ff.cnt0 - 8'h01);
            end
        end
        // Second timer
        if (carry1) begin
            if (eoc1 && st_ff.cfg1[dpt_pkg::PCFG_MODE_BIT]) begin
                nxt_st.cnt1 = st_ff.init1;
            end else if (eoc1) begin
                nxt_st.cnt1  = 8'h00;
                nxt_st.done1 = 1'b1;
            end else begin
                nxt_st.cnt1 = 8'(st_ff.cnt1 - 8'h01);
            end
        end

        // Pending load copies initial values, then the load bit clears itself
        if (load0) begin
            nxt_st.cnt0                        = st_ff.init0;
            nxt_st.prescale_zero_config                        = modulus(st_ff.cfg0);
            nxt_st.done0                       = 1'b0;
            nxt_st.tmode[dpt_pkg::TM_LOAD0_BIT] = 1'b0;
        end
        if (load1) begin
            nxt_st.cnt1                        = st_ff.init1;
            nxt_st.prescale_one_config                        = modulus(st_ff.cfg1);
            nxt_st.done1                       = 1'b0;
            nxt_st.tmode[dpt_pkg::TM_LOAD1_BIT] = 1'b0;
        end

        // End-of-count interrupt pulses
        nxt_st.irq0 = eoc0;
        nxt_st.irq1 = eoc1;

        // Timer output: toggle flip-flop or internal clock image
        nxt_st.clk_half = ~st_ff.clk_half;
        nxt_st.tout_on  = outsel != dpt_pkg::OUTSEL_OFF;
        case (outsel)
            dpt_pkg::OUTSEL_ZERO: begin
                if (load0) begin
                    nxt_st.tout = 1'b1;
                end else if (eoc0) begin
                    nxt_st.tout = ~st_ff.tout;
                end
            end
            dpt_pkg::OUTSEL_ONE: begin
                if (load1) begin
                    nxt_st.tout = 1'b1;
                end else if (eoc1) begin
                    nxt_st.tout = ~st_ff.tout;
                end
            end
            dpt_pkg::OUTSEL_CLK: begin
                nxt_st.tout = st_ff.clk_half;
            end
            default: begin
                nxt_st.tout = st_ff.tout;
            end
        endcase

        // Register writes, accepted at any time, running or not
        if (REG_WR) begin
            case (REG_ADDR)
                dpt_pkg::ADDR_TMODE:     nxt_st.tmode = REG_WDATA;
                dpt_pkg::ADDR_TONE_CNT:  nxt_st.init1 = REG_WDATA;
                dpt_pkg::ADDR_PONE_CFG:  nxt_st.cfg1  = REG_WDATA;
                dpt_pkg::ADDR_TZERO_CNT: nxt_st.init0 = REG_WDATA;
                dpt_pkg::ADDR_PZERO_CFG: nxt_st.cfg0  = REG_WDATA;
                default:                 nxt_st.tmode = nxt_st.tmode;
            endcase
        end

        // Register reads; counts read without disturbing the count
        if (REG_RD) begin
            case (REG_ADDR)
                dpt_pkg::ADDR_TMODE:     nxt_st.rdata = st_ff.tmode;
                dpt_pkg::ADDR_TONE_CNT:  nxt_st.rdata = st_ff.cnt1;
                dpt_pkg::ADDR_PONE_CFG:  nxt_st.rdata = dpt_pkg::PRESCALE_READ;
                dpt_pkg::ADDR_TZERO_CNT: nxt_st.rdata = st_ff.cnt0;
                dpt_pkg::ADDR_PZERO_CFG: nxt_st.rdata = dpt_pkg::PRESCALE_READ;
                default:                 nxt_st.rdata = dpt_pkg::UNMAPPED_READ;
            endcase
        end
    end

    // State register
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from the state register
    assign REG_RDATA            = st_ff.rdata;
    assign PORT3_LINE_SIX_OUT   = st_ff.tout;
    assign PORT3_LINE_SIX_SEL   = st_ff.tout_on;
    assign TIMER_ZERO_INTERRUPT = st_ff.irq0;
    assign TIMER_ONE_INTERRUPT  = st_ff.irq1;

    default clocking dpt_cb @(posedge MCLK);
    endclocking
    default disable iff (RESET);

    // Timer clock comes once every four internal clocks
    property p_tick_spacing;
        tick |=> !tick [*3] ##1 tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("tick spacing wrong");

    // Prescaler reads always answer all ones
    property p_prescale_read;
        REG_RD && (REG_ADDR == dpt_pkg::ADDR_PZERO_CFG || REG_ADDR == dpt_pkg::ADDR_PONE_CFG)
            |=> REG_RDATA == 8'hFF;
    endproperty
    a_prescale_read: assert property (p_prescale_read) else $error("prescaler read not FF");

    // Load bit is gone one clock later and the count holds the initial value
    property p_load_copy;
        load0 && !(REG_WR && REG_ADDR == dpt_pkg::ADDR_TMODE)
            |=> !st_ff.tmode[dpt_pkg::TM_LOAD0_BIT] && st_ff.cnt0 == $past(st_ff.init0);
    endproperty
    a_load_copy: assert property (p_load_copy) else $error("load did not copy");

    // Continuous mode reloads at end-of-count
    property p_cont_reload;
        eoc0 && !load0 && st_ff.cfg0[dpt_pkg::PCFG_MODE_BIT]
            |=> st_ff.cnt0 == $past(st_ff.init0);
    endproperty
    a_cont_reload: assert property (p_cont_reload) else $error("no continuous reload");

    // Single-pass stop holds at zero
    property p_single_hold;
        st_ff.done1 && !load1 |=> st_ff.cnt1 == 8'h00 && $stable(st_ff.prescale_one_config);
    endproperty
    a_single_hold: assert property (p_single_hold) else $error("stopped timer moved");

    // Interrupt pulse follows timer and prescaler both at their end
    property p_irq_cause;
        TIMER_ONE_INTERRUPT |-> $past(carry1) && $past(st_ff.cnt1) == 8'h01;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("spurious interrupt");

    // Prescaler carry reloads modulus
    property p_pre_reload;
        carry0 && !load0 |=> st_ff.prescale_zero_config == $past(st_ff.cfg0[7:2]);
    endproperty
    a_pre_reload: assert property (p_pre_reload) else $error("prescaler not reloaded");

    // Output toggles when the selected timer ends
    property p_tout_toggle;
        outsel == dpt_pkg::OUTSEL_ONE && eoc1 && !load1
            |=> PORT3_LINE_SIX_OUT != $past(PORT3_LINE_SIX_OUT);
    endproperty
    a_tout_toggle: assert property (p_tout_toggle) else $error("output did not toggle");

    // External source: the second prescaler holds unless an input edge or a load comes
    property p_ext_source;
        st_ff.cfg1[dpt_pkg::PCFG_EXT_BIT] && !load1 && !ext_rise |=> $stable(st_ff.prescale_one_config);
    endproperty
    a_ext_source: assert property (p_ext_source) else $error("external count without edge");

endmodule
